/* File: flash_cmd_params.svh */
/*
 * Opcodes, speed limits and reset values of the flash command decoder.
 * Assumes inclusion by the decoder module only; definitions only.
 */
`ifndef FLASH_CMD_PARAMS_SVH
`define FLASH_CMD_PARAMS_SVH

// Instruction codes
`define OPC_QUAD_IO_READ            8'heb
`define OPC_QUAD_IO_READ_LONG       8'hec
`define OPC_DDR_QUAD_IO_READ        8'hed
`define OPC_DDR_QUAD_IO_READ_LONG   8'hee
`define OPC_DDR_DUAL_IO_READ_LONG   8'hbe
`define OPC_PAGE_PROG               8'h02
`define OPC_PAGE_PROG_LONG          8'h12
`define OPC_QUAD_PAGE_PROG          8'h32
`define OPC_QUAD_PAGE_PROG_ALT      8'h38
`define OPC_PARAM_SECTOR_ERASE      8'h20
`define OPC_PARAM_SECTOR_ERASE_LONG 8'h21
`define OPC_SECTOR_ERASE            8'hd8
`define OPC_SECTOR_ERASE_LONG       8'hdc
`define OPC_PROT_LOCK_BIT_WRITE     8'ha6
`define OPC_PROT_LOCK_BIT_READ      8'ha7
`define OPC_RESERVED_HIGH_PERF      8'ha3
`define OPC_RESERVED_E5             8'he5
`define OPC_RESERVED_E6             8'he6
`define OPC_CLEAR_STATUS            8'h30
`define OPC_WRITE_DISABLE           8'h04
`define OPC_WRITE_ENABLE            8'h06
`define OPC_STATUS1_READ            8'h05
`define OPC_STATUS2_READ            8'h07
`define OPC_SOFT_RESET              8'hf0
`define OPC_REG_WRITE               8'h01

// Highest serial clock per command, in MHz
`define FMAX_QUAD_SDR_MHZ           8'h68
`define FMAX_DDR_MHZ                8'h50
`define FMAX_QUAD_PROG_MHZ          8'h50
`define FMAX_STD_MHZ                8'h85

// Field widths and reset values
`define INSTR_BITS                  3'h7
`define PIN_SYNC_IDLE_HIGH          2'h3
`define PIN_SYNC_IDLE_LOW           2'h0
`define WIDTH_SINGLE                3'h1
`define WIDTH_DUAL                  3'h2
`define WIDTH_QUAD                  3'h4

`endif

/* File: flash_cmd_pkg.sv */
/*
 * Types shared by the flash command decoder and its surroundings.
 * Assumes the opcode constants come from flash_cmd_params.svh.
 */
package flash_cmd_pkg;

    typedef enum logic [3:0] {
        CLS_OTHER, CLS_READ, CLS_PROG, CLS_ERASE_PARAM, CLS_ERASE_SECTOR,
        CLS_LOCK_WRITE, CLS_LOCK_READ, CLS_RESERVED, CLS_CLEAR_STATUS,
        CLS_WRITE_DISABLE, CLS_WRITE_ENABLE, CLS_STATUS1_READ,
        CLS_STATUS2_READ, CLS_SOFT_RESET, CLS_REG_WRITE
    } cmd_class_t;

    typedef struct packed {
        logic [7:0] opcode;
        cmd_class_t cls;
        logic       addr4;
        logic       ddr;
        logic [2:0] width;
        logic [7:0] fmax_mhz;
    } cmd_info_t;

    typedef struct packed {
        logic op_in_progress;
        logic write_enable_latch;
        logic prog_err;
        logic erase_err;
    } status_t;

    typedef enum logic [2:0] {
        OP_NONE, OP_PROG, OP_ERASE, OP_LOCK_WRITE, OP_REG_WRITE
    } op_kind_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_INSTR = 2'h1,
        ST_PHASE = 2'h3
    } fsm_state_t;

    typedef struct packed {
        logic [1:0] sck_sync;
        logic [1:0] cs_n_sync;
        logic [1:0] si_sync;
        logic       sck_prev;
        logic [7:0] shift;
        logic [2:0] bit_cnt;
        fsm_state_t fsm;
        op_kind_t   pend;
        op_kind_t   op_run;
        status_t    st;
        logic       cmd_valid;
        logic       cmd_ignored;
        cmd_info_t  cmd_out;
        logic       op_start;
        op_kind_t   op_kind;
        logic       reg_vol_update;
        logic       soft_reset;
    } state_t;

endpackage : flash_cmd_pkg

/* File: flash_cmd_decoder.sv */
/*
 * Instruction decoder and status logic of a serial NOR flash.
 * Assumes SPI mode 0/3 pins from outside, sampled here, and an array
 * engine on core_clk that answers op_start with op_done/op_fail.
 */
// Functional notes
// R1 - EB is quad I/O read with configured address, EC always 4-byte; 104 MHz.
// R2 - ED/EE are DDR quad I/O reads at 80 MHz; BE DDR dual 4-byte.
// R3 - 02 single-line page program configured address; 12 always 4-byte.
// R4 - 32 and 38 are quad page program; host keeps clock at 80 MHz.
// R5 - 20 erases a 4 KB parameter sector; 21 same with 4-byte address.
// R6 - D8 erases a 64/256 KB sector; DC same with 4-byte address.
// R7 - A6 writes, A7 reads the protection lock bit, up to 133 MHz.
// R8 - A3, E5 and E6 are reserved and start nothing.
// R9 - Busy bit stays one during any embedded operation; host polls it.
// R10 - Failed program or erase sets its error bit; busy then stays one.
// R11 - With an error set only clear, disable, status reads, reset run.
// R12 - Host leaves error by clear-status then write-disable.
// R13 - Clear-status clears busy, program-error and erase-error together.
// R14 - Write-disable clears the write enable latch.
// R15 - Hardware reset or software reset F0 also leaves the error state.
// R16 - Register write with changed non-volatile bits runs one embedded write.
// R17 - Host ends the data phase by raising chip select.
// R18 - First byte after chip select falls is the instruction.
`include "flash_cmd_params.svh"
`timescale 1ns/100ps
`default_nettype none

module flash_cmd_decoder
(
    input  wire logic                   core_clk,
    input  wire logic                   nrst,
    input  wire logic                   clk_en,
    input  wire logic                   spi_sck,
    input  wire logic                   spi_cs_n,
    input  wire logic                   spi_si,
    input  wire logic                   addr4_cfg,
    input  wire logic                   nv_bits_changed,
    input  wire logic                   op_done,
    input  wire logic                   op_fail,
    output var  logic                   cmd_valid,
    output var  logic                   cmd_ignored,
    output var  flash_cmd_pkg::cmd_info_t cmd_info,
    output var  logic                   op_start,
    output var  flash_cmd_pkg::op_kind_t  op_kind,
    output var  logic                   reg_vol_update,
    output var  logic                   soft_reset,
    output var  flash_cmd_pkg::status_t   status
);
    import flash_cmd_pkg::*;

    state_t r;
    state_t r_nxt;

    ////////////////////////////////////////////////////////////////////////
    function automatic cmd_info_t decode_opc(input logic [7:0] opc,
                                             input logic       a4);
        cmd_info_t d;
        d          = '0;
        d.opcode   = opc;
        d.cls      = CLS_OTHER;
        d.addr4    = a4;
        d.width    = `WIDTH_SINGLE;
        d.fmax_mhz = `FMAX_STD_MHZ;
        case (opc)
            // R1 quad I/O reads
            `OPC_QUAD_IO_READ, `OPC_QUAD_IO_READ_LONG:
            begin
                d.cls      = CLS_READ;
                d.width    = `WIDTH_QUAD;
                d.fmax_mhz = `FMAX_QUAD_SDR_MHZ;
                d.addr4    = a4 | (opc == `OPC_QUAD_IO_READ_LONG);
            end
            // R2 DDR reads
            `OPC_DDR_QUAD_IO_READ, `OPC_DDR_QUAD_IO_READ_LONG,
            `OPC_DDR_DUAL_IO_READ_LONG:
            begin
                d.cls      = CLS_READ;
                d.ddr      = 1'b1;
                d.fmax_mhz = `FMAX_DDR_MHZ;
                d.width    = (opc == `OPC_DDR_DUAL_IO_READ_LONG) ?
                             `WIDTH_DUAL : `WIDTH_QUAD;
                d.addr4    = a4 | (opc != `OPC_DDR_QUAD_IO_READ);
            end
            // R3 single-line page program
            `OPC_PAGE_PROG, `OPC_PAGE_PROG_LONG:
            begin
                d.cls   = CLS_PROG;
                d.addr4 = a4 | (opc == `OPC_PAGE_PROG_LONG);
            end
            // R4 quad page program, both codes
            `OPC_QUAD_PAGE_PROG, `OPC_QUAD_PAGE_PROG_ALT:
            begin
                d.cls      = CLS_PROG;
                d.width    = `WIDTH_QUAD;
                d.fmax_mhz = `FMAX_QUAD_PROG_MHZ;
            end
            // R5 parameter sector erase
            `OPC_PARAM_SECTOR_ERASE, `OPC_PARAM_SECTOR_ERASE_LONG:
            begin
                d.cls   = CLS_ERASE_PARAM;
                d.addr4 = a4 | (opc == `OPC_PARAM_SECTOR_ERASE_LONG);
            end
            // R6 sector erase
            `OPC_SECTOR_ERASE, `OPC_SECTOR_ERASE_LONG:
            begin
                d.cls   = CLS_ERASE_SECTOR;
                d.addr4 = a4 | (opc == `OPC_SECTOR_ERASE_LONG);
            end
            // R7 lock bit access
            `OPC_PROT_LOCK_BIT_WRITE: d.cls = CLS_LOCK_WRITE;
            `OPC_PROT_LOCK_BIT_READ:  d.cls = CLS_LOCK_READ;
            // R8 reserved codes
            `OPC_RESERVED_HIGH_PERF, `OPC_RESERVED_E5, `OPC_RESERVED_E6:
                d.cls = CLS_RESERVED;
            `OPC_CLEAR_STATUS:  d.cls = CLS_CLEAR_STATUS;
            `OPC_WRITE_DISABLE: d.cls = CLS_WRITE_DISABLE;
            `OPC_WRITE_ENABLE:  d.cls = CLS_WRITE_ENABLE;
            `OPC_STATUS1_READ:  d.cls = CLS_STATUS1_READ;
            `OPC_STATUS2_READ:  d.cls = CLS_STATUS2_READ;
            `OPC_SOFT_RESET:    d.cls = CLS_SOFT_RESET;
            `OPC_REG_WRITE:     d.cls = CLS_REG_WRITE;
            default:            d.cls = CLS_OTHER;
        endcase
        return d;
    endfunction : decode_opc

    function automatic op_kind_t kind_of(input cmd_class_t c);
        case (c)
            CLS_PROG:                         return OP_PROG;
            CLS_ERASE_PARAM, CLS_ERASE_SECTOR: return OP_ERASE;
            CLS_LOCK_WRITE:                   return OP_LOCK_WRITE;
            CLS_REG_WRITE:                    return OP_REG_WRITE;
            default:                          return OP_NONE;
        endcase
    endfunction : kind_of

    ////////////////////////////////////////////////////////////////////////
    logic       sck_rise;
    logic       cs_active;
    logic       err_any;
    logic [7:0] opc_in;
    cmd_info_t  dec;
    logic       allowed;

    always_comb
    begin
        sck_rise  = r.sck_sync[1] & ~r.sck_prev;
        cs_active = ~r.cs_n_sync[1];
        err_any   = r.st.prog_err | r.st.erase_err;
        opc_in    = {r.shift[6:0], r.si_sync[1]};
        dec       = decode_opc(opc_in, addr4_cfg);
        // R11 restricted set in error state
        allowed   = ~err_any
                  | (dec.cls == CLS_CLEAR_STATUS)
                  | (dec.cls == CLS_WRITE_DISABLE)
                  | (dec.cls == CLS_STATUS1_READ)
                  | (dec.cls == CLS_STATUS2_READ)
                  | (dec.cls == CLS_SOFT_RESET);
    end

    always_comb
    begin
        r_nxt = r;
        // Pulses last one enabled cycle
        r_nxt.cmd_valid      = 1'b0;
        r_nxt.cmd_ignored    = 1'b0;
        r_nxt.op_start       = 1'b0;
        r_nxt.reg_vol_update = 1'b0;
        r_nxt.soft_reset     = 1'b0;
        // Only the second stage is ever read
        r_nxt.sck_sync  = {r.sck_sync[0], spi_sck};
        r_nxt.cs_n_sync = {r.cs_n_sync[0], spi_cs_n};
        r_nxt.si_sync   = {r.si_sync[0], spi_si};
        r_nxt.sck_prev  = r.sck_sync[1];

        case (r.fsm)
            ST_IDLE:
            begin
                // R18 frame start arms instruction capture
                if (cs_active)
                begin
                    r_nxt.fsm     = ST_INSTR;
                    r_nxt.bit_cnt = 3'h0;
                end
            end
            ST_INSTR:
            begin
                if (!cs_active)
                    r_nxt.fsm = ST_IDLE;
                else if (sck_rise)
                begin
                    r_nxt.shift   = opc_in;
                    r_nxt.bit_cnt = r.bit_cnt + 3'h1;
                    if (r.bit_cnt == `INSTR_BITS)
                    begin
                        // R18 eighth bit completes the instruction
                        r_nxt.fsm = ST_PHASE;
                        if (allowed)
                        begin
                            r_nxt.cmd_valid = 1'b1;
                            r_nxt.cmd_out   = dec;
                            case (dec.cls)
                                // R14 write disable
                                CLS_WRITE_DISABLE:
                                    r_nxt.st.write_enable_latch = 1'b0;
                                CLS_WRITE_ENABLE:
                                    r_nxt.st.write_enable_latch = 1'b1;
                                // R13 clear-status drops both errors
                                CLS_CLEAR_STATUS:
                                begin
                                    r_nxt.st.prog_err  = 1'b0;
                                    r_nxt.st.erase_err = 1'b0;
                                end
                                // R15 software reset back to standby
                                CLS_SOFT_RESET:
                                begin
                                    r_nxt.soft_reset = 1'b1;
                                    r_nxt.st         = '0;
                                    r_nxt.op_run     = OP_NONE;
                                    r_nxt.pend       = OP_NONE;
                                end
                                default:
                                begin
                                    // Busy array cannot take a second job
                                    if (r.st.write_enable_latch &&
                                        !r.st.op_in_progress)
                                        r_nxt.pend = kind_of(dec.cls);
                                end
                            endcase
                        end
                        else
                            r_nxt.cmd_ignored = 1'b1;
                    end
                end
            end
            ST_PHASE:
            begin
                // R17 chip select high ends the phase
                if (!cs_active)
                begin
                    r_nxt.fsm  = ST_IDLE;
                    r_nxt.pend = OP_NONE;
                    // R16 volatile-only register writes skip the array
                    if (r.pend == OP_REG_WRITE && !nv_bits_changed)
                        r_nxt.reg_vol_update = 1'b1;
                    else if (r.pend != OP_NONE)
                    begin
                        r_nxt.op_start = 1'b1;
                        r_nxt.op_kind  = r.pend;
                        r_nxt.op_run   = r.pend;
                    end
                end
            end
            default:
                r_nxt.fsm = ST_IDLE;
        endcase

        // R10 result of the embedded operation; a set beats clear-status
        if (op_done && r.op_run != OP_NONE)
        begin
            r_nxt.op_run = OP_NONE;
            if (op_fail && r.op_run == OP_ERASE)
                r_nxt.st.erase_err = 1'b1;
            else if (op_fail)
                r_nxt.st.prog_err = 1'b1;
            else
                r_nxt.st.write_enable_latch = 1'b0;
        end

        // R9 busy follows the running job, R10 and held by errors
        r_nxt.st.op_in_progress = (r_nxt.op_run != OP_NONE)
                                | r_nxt.st.prog_err | r_nxt.st.erase_err;

        // Clock enable low freezes everything
        if (!clk_en)
            r_nxt = r;
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            // R15 hardware reset clears the error state
            r           <= '0;
            r.sck_sync  <= `PIN_SYNC_IDLE_LOW;
            r.cs_n_sync <= `PIN_SYNC_IDLE_HIGH;
            r.sck_prev  <= 1'b0;
        end
        else
            r <= r_nxt;
    end

    always_comb
    begin
        cmd_valid      = r.cmd_valid;
        cmd_ignored    = r.cmd_ignored;
        cmd_info       = r.cmd_out;
        op_start       = r.op_start;
        op_kind        = r.op_kind;
        reg_vol_update = r.reg_vol_update;
        soft_reset     = r.soft_reset;
        status         = r.st;
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking dcb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    property p_quad_read;
        cmd_valid && cmd_info.opcode == `OPC_QUAD_IO_READ_LONG |->
            cmd_info.cls == CLS_READ && cmd_info.addr4 &&
            cmd_info.width == `WIDTH_QUAD;
    endproperty
    a_quad_read: assert property (p_quad_read) // R1
        else $error("long quad read decoded wrongly");

    property p_ddr_read;
        cmd_valid && (cmd_info.opcode == `OPC_DDR_QUAD_IO_READ ||
                      cmd_info.opcode == `OPC_DDR_DUAL_IO_READ_LONG) |->
            cmd_info.ddr && cmd_info.fmax_mhz == `FMAX_DDR_MHZ;
    endproperty
    a_ddr_read: assert property (p_ddr_read) // R2
        else $error("ddr read decoded wrongly");

    property p_prog_long;
        cmd_valid && cmd_info.opcode == `OPC_PAGE_PROG_LONG |->
            cmd_info.cls == CLS_PROG && cmd_info.addr4;
    endproperty
    a_prog_long: assert property (p_prog_long) // R3
        else $error("long page program decoded wrongly");

    property p_quad_prog;
        cmd_valid && cmd_info.opcode == `OPC_QUAD_PAGE_PROG_ALT |->
            cmd_info.cls == CLS_PROG && cmd_info.width == `WIDTH_QUAD;
    endproperty
    a_quad_prog: assert property (p_quad_prog) // R4
        else $error("alternate quad program decoded wrongly");

    property p_erase_long;
        cmd_valid && cmd_info.opcode == `OPC_SECTOR_ERASE_LONG |->
            cmd_info.cls == CLS_ERASE_SECTOR && cmd_info.addr4;
    endproperty
    a_erase_long: assert property (p_erase_long) // R6
        else $error("long sector erase decoded wrongly");

    property p_reserved_quiet;
        cmd_valid && cmd_info.cls == CLS_RESERVED |->
            ##1 (!op_start) [*8];
    endproperty
    a_reserved_quiet: assert property (p_reserved_quiet) // R8
        else $error("reserved code started an operation");

    property p_err_busy;
        status.prog_err || status.erase_err |-> status.op_in_progress;
    endproperty
    a_err_busy: assert property (p_err_busy) // R10
        else $error("error bit without busy bit");

    property p_err_filter;
        cmd_valid && $past(status.prog_err || status.erase_err) |->
            cmd_info.cls inside {CLS_CLEAR_STATUS, CLS_WRITE_DISABLE,
            CLS_STATUS1_READ, CLS_STATUS2_READ, CLS_SOFT_RESET};
    endproperty
    a_err_filter: assert property (p_err_filter) // R11
        else $error("command accepted in error state");

    property p_clear_status;
        cmd_valid && cmd_info.cls == CLS_CLEAR_STATUS &&
            $past(r.op_run == OP_NONE) |->
            !status.prog_err && !status.erase_err && !status.op_in_progress;
    endproperty
    a_clear_status: assert property (p_clear_status) // R13
        else $error("clear-status left a status bit set");

    property p_write_disable;
        cmd_valid && cmd_info.cls == CLS_WRITE_DISABLE |->
            !status.write_enable_latch;
    endproperty
    a_write_disable: assert property (p_write_disable) // R14
        else $error("write-disable left the latch set");

    property p_soft_reset;
        soft_reset |-> status == '0;
    endproperty
    a_soft_reset: assert property (p_soft_reset) // R15
        else $error("software reset left status set");

    c_prog_start: cover property (op_start && op_kind == OP_PROG);
    c_err_ignored: cover property (cmd_ignored && status.prog_err);
    c_vol_update: cover property (reg_vol_update);
    c_erase_fail: cover property (status.erase_err);

endmodule : flash_cmd_decoder

`default_nettype wire

/* File: spi_host_model.sv */
/* Host controller model: one mode 0 frame per instruction byte.
   Assumes the bench calls send() and waits for its return. */
`timescale 1ns/100ps
`default_nettype none
module spi_host_model
(
    output var logic sck,
    output var logic cs_n,
    output var logic si
);
    initial
    begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b1;
    end
    task automatic send(input logic [7:0] b, input int nbits = 8);
        #7 cs_n = 1'b0;
        // Fewer than eight bits makes a cut frame
        for (int i = 7; i >= 8 - nbits; i--)
        begin
            si = b[i];
            #160 sck = 1'b1;
            #160 sck = 1'b0;
        end
        #80 cs_n = 1'b1;
        // Released line must not keep its value
        si = ~si;
        #200;
    endtask : send
endmodule : spi_host_model
`default_nettype wire

/* File: spi_flash_command_decoder_test.sv */
/* Self-checking bench of the flash command decoder.
   Assumes the design files and the host model are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module spi_flash_command_decoder_test;
    import flash_cmd_pkg::*;
    logic        core_clk, nrst, addr4_cfg, nv_bits_changed;
    logic        op_done = 1'b0, op_fail = 1'b0, fail_mode, clk_en;
    wire logic   sck, cs_n, si;
    logic        cmd_valid, cmd_ignored, op_start, reg_vol_update, soft_reset;
    cmd_info_t   cmd_info;
    op_kind_t    op_kind, exp_kind;
    status_t     status;
    logic [15:0] notes[$];
    logic [15:0] nt, m;
    logic [31:0] rng;
    int          bad_count, n_compared, n_starts, n_vol, n_soft;
    localparam logic [7:0] OPS [18] = '{8'heb, 8'hec, 8'hed, 8'hee,
        8'hbe, 8'h02, 8'h12, 8'h32, 8'h38, 8'h20, 8'h21, 8'hd8, 8'hdc,
        8'ha6, 8'ha7, 8'ha3, 8'he5, 8'he6};
    localparam logic [17:0] LONG_M = 18'h0145a;
    localparam logic [17:0] DDR_M  = 18'h0001c;

    spi_host_model host (.sck(sck), .cs_n(cs_n), .si(si));
    flash_cmd_decoder uut (.core_clk(core_clk), .nrst(nrst),
        .clk_en(clk_en), .spi_sck(sck), .spi_cs_n(cs_n), .spi_si(si),
        .addr4_cfg(addr4_cfg), .nv_bits_changed(nv_bits_changed),
        .op_done(op_done), .op_fail(op_fail), .cmd_valid(cmd_valid),
        .cmd_ignored(cmd_ignored), .cmd_info(cmd_info),
        .op_start(op_start), .op_kind(op_kind),
        .reg_vol_update(reg_vol_update), .soft_reset(soft_reset),
        .status(status));

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    function automatic cmd_class_t cls_of(input int i);
        if (i < 5) return CLS_READ;
        if (i < 9) return CLS_PROG;
        if (i < 11) return CLS_ERASE_PARAM;
        if (i < 13) return CLS_ERASE_SECTOR;
        if (i == 13) return CLS_LOCK_WRITE;
        if (i == 14) return CLS_LOCK_READ;
        return CLS_RESERVED;
    endfunction : cls_of

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test

    // Note bits: ignored, check fields, ddr, long address, class, opcode
    task automatic frame(input logic [7:0] op, input logic ign,
                         input cmd_class_t c, input logic [2:0] f);
        notes.push_back({ign, f, c, op});
        host.send(op);
        repeat (4) @(posedge core_clk);
    endtask : frame

    task automatic wait_idle;
        int k;
        for (k = 0; k < 200 && status.op_in_progress !== 1'b0; k++)
            @(posedge core_clk);
        if (k == 200)
        begin
            bad_count++;
            end_of_test;
        end
    endtask : wait_idle

    task automatic fail_op(input logic [7:0] op, input cmd_class_t c,
                           input op_kind_t k, input logic [3:0] e);
        frame(8'h06, 1'b0, CLS_WRITE_ENABLE, 3'h0);
        fail_mode = 1'b1;
        exp_kind = k;
        frame(op, 1'b0, c, 3'h0);
        repeat (30) @(posedge core_clk);
        chk("status", 32'(e), 32'(status));
    endtask : fail_op

    always @(negedge core_clk)
    begin
        if (cmd_valid === 1'b1 || cmd_ignored === 1'b1)
        begin
            nt = (notes.size() > 0) ? notes.pop_front() : 16'hffff;
            m = {2'h0, {2{nt[14]}}, 12'hfff};
            chk("ignored", 32'(nt[15]), 32'(cmd_ignored));
            if (nt[15] == 1'b0)
                chk("cmd", 32'(nt & m), 32'({2'h0, cmd_info.ddr, cmd_info.addr4, cmd_info.cls, cmd_info.opcode} & m));
        end
        if (reg_vol_update === 1'b1)
            n_vol++;
        if (soft_reset === 1'b1)
            n_soft++;
        if (op_start === 1'b1)
        begin
            n_starts++;
            chk("op_kind", 32'(exp_kind), 32'(op_kind));
        end
    end

    // Array engine stub answers each job late
    always @(negedge core_clk)
        if (op_start === 1'b1)
        begin
            repeat (20) @(posedge core_clk);
            op_done <= 1'b1;
            op_fail <= fail_mode;
            @(posedge core_clk);
            op_done <= 1'b0;
            op_fail <= 1'b0;
        end

    initial
    begin
        nrst = 1'b0;
        addr4_cfg = 1'b0;
        nv_bits_changed = 1'b0;
        clk_en = 1'b1;
        fail_mode = 1'b0;
        exp_kind = OP_NONE;
        rng = 32'h0000e333;
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        for (int i = 0; i < 18; i++)
        begin
            rng = xs(rng);
            addr4_cfg <= rng[0];
            @(posedge core_clk);
            frame(OPS[i], 1'b0, cls_of(i), {i < 13, DDR_M[i], LONG_M[i] | addr4_cfg});
        end
        chk("starts", 32'h0, 32'(n_starts));
        $display("decode table done");
        host.send(8'h06, 5);
        repeat (4) @(posedge core_clk);
        chk("cut frame", 32'h0, 32'(status));
        frame(8'h06, 1'b0, CLS_WRITE_ENABLE, 3'h0);
        chk("status", 32'h4, 32'(status));
        clk_en <= 1'b0;
        host.send(8'h04);
        @(posedge core_clk);
        clk_en <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk("frozen", 32'h4, 32'(status));
        exp_kind = OP_PROG;
        frame(8'h02, 1'b0, CLS_PROG, 3'h0);
        chk("status", 32'hc, 32'(status));
        wait_idle;
        chk("status", 32'h0, 32'(status));
        exp_kind = OP_LOCK_WRITE;
        frame(8'h06, 1'b0, CLS_WRITE_ENABLE, 3'h0);
        frame(8'ha6, 1'b0, CLS_LOCK_WRITE, 3'h0);
        wait_idle;
        $display("program done");
        fail_op(8'h02, CLS_PROG, OP_PROG, 4'he);
        frame(8'heb, 1'b1, CLS_READ, 3'h0);
        frame(8'h06, 1'b1, CLS_WRITE_ENABLE, 3'h0);
        frame(8'h05, 1'b0, CLS_STATUS1_READ, 3'h0);
        frame(8'h07, 1'b0, CLS_STATUS2_READ, 3'h0);
        frame(8'h30, 1'b0, CLS_CLEAR_STATUS, 3'h0);
        chk("status", 32'h4, 32'(status));
        frame(8'h04, 1'b0, CLS_WRITE_DISABLE, 3'h0);
        chk("status", 32'h0, 32'(status));
        $display("error exit done");
        fail_op(8'h20, CLS_ERASE_PARAM, OP_ERASE, 4'hd);
        frame(8'hf0, 1'b0, CLS_SOFT_RESET, 3'h0);
        chk("status", 32'h0, 32'(status));
        fail_op(8'hdc, CLS_ERASE_SECTOR, OP_ERASE, 4'hd);
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk("status", 32'h0, 32'(status));
        $display("reset exit done");
        fail_mode = 1'b0;
        nv_bits_changed <= 1'b1;
        exp_kind = OP_REG_WRITE;
        frame(8'h06, 1'b0, CLS_WRITE_ENABLE, 3'h0);
        frame(8'h01, 1'b0, CLS_REG_WRITE, 3'h0);
        chk("status", 32'hc, 32'(status));
        wait_idle;
        nv_bits_changed <= 1'b0;
        frame(8'h06, 1'b0, CLS_WRITE_ENABLE, 3'h0);
        frame(8'h01, 1'b0, CLS_REG_WRITE, 3'h0);
        chk("volatile", 32'h1, 32'(n_vol));
        chk("starts", 32'h6, 32'(n_starts));
        chk("soft resets", 32'h1, 32'(n_soft));
        chk("notes left", 32'h0, 32'(notes.size()));
        $display("register write done");
        end_of_test;
    end
endmodule : spi_flash_command_decoder_test
`default_nettype wire
